// File: design/cei_cfg.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 comparator event block. Assumes a 32-bit AXI4-Lite register bus.
*/
`ifndef CEI_CFG_SVH
`define CEI_CFG_SVH

// ==========================================================
// Register byte offsets
`define CEI_OFS_CSR      8'h00
`define CEI_OFS_DIGITAL_INPUT_DISABLE     8'h04
`define CEI_OFS_IRQ_STAT 8'h08
`define CEI_OFS_IRQ_CLR  8'h0C
`define CEI_OFS_IRQ_EN   8'h10

// ==========================================================
// Field positions
`define CEI_CSR_OUT      5
`define CEI_CSR_FLAG     4
`define CEI_CSR_IE       3
`define CEI_CSR_ROUTE    2
`define CEI_CSR_SEL_HI   1
`define CEI_CSR_SEL_LO   0
`define CEI_DIGITAL_INPUT_DISABLE_NEG     1
`define CEI_DIGITAL_INPUT_DISABLE_POS     0
`define CEI_IRQ_EVT      0
`define CEI_IRQ_TOG      1

// ==========================================================
// Reset values, responses and timing
`define CEI_CSR_RST      8'h00
`define CEI_DIGITAL_INPUT_DISABLE_RST     2'h0
`define CEI_IRQ_RST      2'h0
`define CEI_RESP_OKAY    2'h0
`define CEI_RESP_SLVERR  2'h2
`define CEI_SYNC_STAGES  2

`endif

// File: design/cei_pkg.sv
/*
 Types shared by the comparator event block.
 Assumes nothing beyond a SystemVerilog tool.
*/
package cei_pkg;

	typedef enum logic [1:0]
	{
		CEI_SEL_TOGGLE = 2'h0,
		CEI_SEL_RSVD   = 2'h1,
		CEI_SEL_FALL   = 2'h2,
		CEI_SEL_RISE   = 2'h3
	} cei_sel_t;

	typedef struct packed
	{
		logic     ie;
		logic     route;
		cei_sel_t sel;
	} cei_ctrl_t;

	typedef struct packed
	{
		logic rise;
		logic fall;
		logic tog;
	} cei_edges_t;

	typedef enum logic [1:0]
	{
		CEI_RD_IDLE = 2'b01,
		CEI_RD_DATA = 2'b10
	} cei_rd_state_t;

endpackage

// File: design/cei_sync.sv
/*
 Two-flop synchroniser, one chain per bit.
 Assumes d may change at any time with respect to clk.
*/
`include "cei_cfg.svh"

module cei_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             clk_en,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	import cei_pkg::*;

	localparam int S = `CEI_SYNC_STAGES;

	if (WIDTH < 1)
	begin : g_bad
		$error("cei_sync: WIDTH must be at least 1");
	end

	// ==========================================================
	// Per-bit chains
	for (genvar i = 0; i < WIDTH; i++)
	begin : g_bit
		logic [S-1:0] st_r;

		// The first flop feeds only the second one
		always_ff @(posedge clk)
		begin
			if (!reset_n)
				st_r <= '0;
			else if (clk_en)
				st_r <= {st_r[S-2:0], d[i]};
		end

		assign q[i] = st_r[S-1];
	end

	// ==========================================================
	// Checks
	a_sync_delay:
	assert property (@(posedge clk) disable iff (!reset_n)
		$past(clk_en) && $past(clk_en, 2) && $past(reset_n) &&
		$past(reset_n, 2) |-> q == $past(d, 2))
	else
		$error("synchronised output is not the input two clocks earlier");

endmodule

// File: design/cei_edge.sv
/*
 Edge detector on the synchronised comparator level.
 Assumes lvl is already synchronous to clk.
*/
module cei_edge
(
	input  wire logic               clk,
	input  wire logic               reset_n,
	input  wire logic               clk_en,
	input  wire logic               lvl,
	output cei_pkg::cei_edges_t     edges
);
	import cei_pkg::*;

	logic prev_r;
	logic primed_r;

	// Primed keeps the first sample after reset from faking an edge
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			prev_r   <= 1'b0;
			primed_r <= 1'b0;
		end
		else if (clk_en)
		begin
			prev_r   <= lvl;
			primed_r <= 1'b1;
		end
	end

	assign edges.rise = primed_r & lvl & ~prev_r;
	assign edges.fall = primed_r & ~lvl & prev_r;
	assign edges.tog  = edges.rise | edges.fall;

	a_edge_single:
	assert property (@(posedge clk) disable iff (!reset_n)
		clk_en && (edges.rise || edges.fall) |=>
		!(edges.rise && $past(edges.rise)) &&
		!(edges.fall && $past(edges.fall)))
	else
		$error("edge pulse repeated in the same direction");

endmodule

// File: design/cei_top.sv
/*
 Comparator event and interrupt logic with an AXI4-Lite register slave.
 Assumes a raw comparator level, a CPU that pulses vector_ack when it
 enters the comparator vector, and a timer capture front end.
*/
// Function
// - The event flag is set whenever the chosen comparator event occurs.
// - Entering the comparator interrupt vector clears the event flag.
// - Writing one to the flag position clears it, writing zero keeps it.
// - The request is raised only with flag, local and global enable set.
// - The capture route bit steers the comparator into the timer capture.
// - Select 00 toggle, 01 reserved, 10 falling and 11 rising edge.
// - A pin's disable bit turns off its input buffer and reads it as zero.
// - The comparator output is synchronised, costing one to two clocks.
`include "cei_cfg.svh"

module cei_top
#(
	parameter int AW = 8
)
(
	input  wire logic          clk,
	input  wire logic          reset_n,
	input  wire logic          clk_en,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire logic          cmp_raw,
	input  wire logic          pos_pin_raw,
	input  wire logic          neg_pin_raw,
	input  wire logic          icp_pin,
	input  wire logic          global_irq_en,
	input  wire logic          vector_ack,
	output logic               cmp_irq_req,
	output logic               capture_in,
	output logic               port_pin_pos,
	output logic               port_pin_neg,
	output logic               pos_digin_en,
	output logic               neg_digin_en,
	output logic               irq
);
	import cei_pkg::*;

	if (AW < 5 || AW > 32)
	begin : g_bad
		$error("cei_top: AW must lie between 5 and 32");
	end

	// ==========================================================
	// Declarations
	logic          aw_hold_r;
	logic          w_hold_r;
	logic [AW-1:0] aw_addr_r;
	logic [7:0]    w_data_r;
	logic          w_lane_r;
	logic          bvalid_r;
	logic [1:0]    bresp_r;
	cei_rd_state_t rd_st_r;
	cei_rd_state_t rd_st_nxt;
	logic [7:0]    rdata_r;
	logic [1:0]    rresp_r;
	cei_ctrl_t     ctrl_r;
	logic          flag_r;
	logic          flag_nxt;
	logic          pos_off_r;
	logic          neg_off_r;
	logic [1:0]    irq_stat_r;
	logic [1:0]    irq_stat_nxt;
	logic [1:0]    irq_en_r;
	logic          cmp_sync;
	cei_edges_t    edges;

	wire aw_take  = s_axi_awvalid & s_axi_awready;
	wire w_take   = s_axi_wvalid & s_axi_wready;
	wire ar_take  = s_axi_arvalid & s_axi_arready;
	wire do_write = clk_en & aw_hold_r & w_hold_r;

	// ==========================================================
	// Synchroniser and edge detector
	cei_sync #(.WIDTH(1)) u_sync
	(
		.clk     (clk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.d       (cmp_raw),
		.q       (cmp_sync)
	);

	cei_edge u_edge
	(
		.clk     (clk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.lvl     (cmp_sync),
		.edges   (edges)
	);

	// ==========================================================
	// Address decode
	wire hit_w_csr  = aw_addr_r == AW'(`CEI_OFS_CSR);
	wire hit_w_digital_input_disable = aw_addr_r == AW'(`CEI_OFS_DIGITAL_INPUT_DISABLE);
	wire hit_w_stat = aw_addr_r == AW'(`CEI_OFS_IRQ_STAT);
	wire hit_w_clr  = aw_addr_r == AW'(`CEI_OFS_IRQ_CLR);
	wire hit_w_en   = aw_addr_r == AW'(`CEI_OFS_IRQ_EN);
	wire w_mapped   = hit_w_csr | hit_w_digital_input_disable | hit_w_stat | hit_w_clr |
	                  hit_w_en;
	wire wr_ok      = do_write & w_lane_r;
	wire wr_csr     = wr_ok & hit_w_csr;
	wire wr_digital_input_disable    = wr_ok & hit_w_digital_input_disable;
	wire wr_clr     = wr_ok & hit_w_clr;
	wire wr_en      = wr_ok & hit_w_en;

	wire hit_r_csr  = s_axi_araddr == AW'(`CEI_OFS_CSR);
	wire hit_r_digital_input_disable = s_axi_araddr == AW'(`CEI_OFS_DIGITAL_INPUT_DISABLE);
	wire hit_r_stat = s_axi_araddr == AW'(`CEI_OFS_IRQ_STAT);
	wire hit_r_clr  = s_axi_araddr == AW'(`CEI_OFS_IRQ_CLR);
	wire hit_r_en   = s_axi_araddr == AW'(`CEI_OFS_IRQ_EN);
	wire r_mapped   = hit_r_csr | hit_r_digital_input_disable | hit_r_stat | hit_r_clr |
	                  hit_r_en;

	wire [7:0] csr_view = {2'h0, cmp_sync, flag_r, ctrl_r.ie,
	                       ctrl_r.route, ctrl_r.sel};
	wire [7:0] rd_byte  = hit_r_csr  ? csr_view :
	                      hit_r_digital_input_disable ? {6'h00, neg_off_r, pos_off_r} :
	                      hit_r_stat ? {6'h00, irq_stat_r} :
	                      hit_r_en   ? {6'h00, irq_en_r} : 8'h00;

	// ==========================================================
	// Bus handshakes
	// Address and data are caught separately, so either may come first
	assign s_axi_awready = clk_en & ~aw_hold_r & ~bvalid_r;
	assign s_axi_wready  = clk_en & ~w_hold_r & ~bvalid_r;
	// Valids are masked while frozen so a master never sees a handshake
	// that the frozen slave cannot retire
	assign s_axi_bvalid  = clk_en & bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = clk_en & (rd_st_r == CEI_RD_IDLE);
	assign s_axi_rvalid  = clk_en & (rd_st_r == CEI_RD_DATA);
	assign s_axi_rdata   = {24'h00_0000, rdata_r};
	assign s_axi_rresp   = rresp_r;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			aw_addr_r <= '0;
			w_data_r  <= 8'h00;
			w_lane_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `CEI_RESP_OKAY;
		end
		else if (clk_en)
		begin
			if (aw_take)
				aw_addr_r <= s_axi_awaddr;
			if (w_take)
			begin
				w_data_r <= s_axi_wdata[7:0];
				w_lane_r <= s_axi_wstrb[0];
			end
			aw_hold_r <= (aw_hold_r | aw_take) & ~do_write;
			w_hold_r  <= (w_hold_r | w_take) & ~do_write;
			if (do_write)
			begin
				bvalid_r <= 1'b1;
				bresp_r  <= w_mapped ? `CEI_RESP_OKAY : `CEI_RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_r <= 1'b0;
		end
	end

	always_comb
	begin
		rd_st_nxt = rd_st_r;
		unique case (rd_st_r)
			CEI_RD_IDLE:
				if (ar_take)
					rd_st_nxt = CEI_RD_DATA;
			CEI_RD_DATA:
				if (s_axi_rready)
					rd_st_nxt = CEI_RD_IDLE;
			default:
				rd_st_nxt = CEI_RD_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			rd_st_r <= CEI_RD_IDLE;
			rdata_r <= 8'h00;
			rresp_r <= `CEI_RESP_OKAY;
		end
		else if (clk_en)
		begin
			rd_st_r <= rd_st_nxt;
			if (ar_take)
			begin
				rdata_r <= rd_byte;
				rresp_r <= r_mapped ? `CEI_RESP_OKAY : `CEI_RESP_SLVERR;
			end
		end
	end

	// ==========================================================
	// Event selection and flag
	// Mode 01 never fires; a mode change alone cannot fire either
	wire evt_hit = (ctrl_r.sel == CEI_SEL_TOGGLE) ? edges.tog :
	               (ctrl_r.sel == CEI_SEL_FALL)   ? edges.fall :
	               (ctrl_r.sel == CEI_SEL_RISE)   ? edges.rise : 1'b0;

	wire flag_clr = vector_ack |
	                (wr_csr & w_data_r[`CEI_CSR_FLAG]);

	// A new event wins over a clear in the same cycle
	assign flag_nxt = evt_hit | (flag_r & ~flag_clr);

	assign irq_stat_nxt = (irq_stat_r & ~(wr_clr ? w_data_r[1:0] : 2'h0)) |
	                      {edges.tog, evt_hit};

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			ctrl_r     <= cei_ctrl_t'(4'(`CEI_CSR_RST));
			flag_r     <= 1'b0;
			pos_off_r  <= 1'b0;
			neg_off_r  <= 1'b0;
			irq_stat_r <= `CEI_IRQ_RST;
			irq_en_r   <= `CEI_IRQ_RST;
		end
		else if (clk_en)
		begin
			flag_r     <= flag_nxt;
			irq_stat_r <= irq_stat_nxt;
			if (wr_csr)
				ctrl_r <= cei_ctrl_t'(w_data_r[`CEI_CSR_IE:`CEI_CSR_SEL_LO]);
			if (wr_digital_input_disable)
			begin
				pos_off_r <= w_data_r[`CEI_DIGITAL_INPUT_DISABLE_POS];
				neg_off_r <= w_data_r[`CEI_DIGITAL_INPUT_DISABLE_NEG];
			end
			if (wr_en)
				irq_en_r <= w_data_r[1:0];
		end
	end

	// ==========================================================
	// Outputs toward CPU, timer and pins
	assign cmp_irq_req = flag_r & ctrl_r.ie & global_irq_en;
	assign irq         = |(irq_stat_r & irq_en_r);
	assign pos_digin_en = ~pos_off_r;
	assign neg_digin_en = ~neg_off_r;

	// Registered so pin and capture data leave from flops
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			capture_in   <= 1'b0;
			port_pin_pos <= 1'b0;
			port_pin_neg <= 1'b0;
		end
		else if (clk_en)
		begin
			capture_in   <= ctrl_r.route ? cmp_sync : icp_pin;
			port_pin_pos <= pos_pin_raw & ~pos_off_r;
			port_pin_neg <= neg_pin_raw & ~neg_off_r;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_flag_on_event:
	assert property (clk_en && evt_hit |=> flag_r)
	else
		$error("event did not set the flag");

	a_flag_vec_clear:
	assert property (clk_en && vector_ack && !evt_hit |=> !flag_r)
	else
		$error("vector entry did not clear the flag");

	a_flag_w1c:
	assert property (clk_en && wr_csr && w_data_r[`CEI_CSR_FLAG] &&
		!evt_hit |=> !flag_r)
	else
		$error("writing one did not clear the flag");

	a_flag_w0_keep:
	assert property (clk_en && flag_r && !vector_ack &&
		!(wr_csr && w_data_r[`CEI_CSR_FLAG]) |=> flag_r)
	else
		$error("flag dropped without a clear");

	a_req_gated:
	assert property (clk_en && wr_csr && !w_data_r[`CEI_CSR_IE] |=>
		!cmp_irq_req)
	else
		$error("request stayed up after the enable was cleared");

	a_req_raised:
	assert property (clk_en && evt_hit && ctrl_r.ie && global_irq_en &&
		!wr_csr |=> cmp_irq_req || !global_irq_en)
	else
		$error("request missing after an enabled event");

	a_capture_route:
	assert property (clk_en |=>
		capture_in == ($past(ctrl_r.route) ? $past(cmp_sync) : $past(icp_pin)))
	else
		$error("capture input not taken from the selected source");

	a_mode_reserved:
	assert property (clk_en && ctrl_r.sel == CEI_SEL_RSVD && !flag_r |=>
		!flag_r)
	else
		$error("reserved select mode set the flag");

	a_mode_rising:
	assert property (clk_en && ctrl_r.sel == CEI_SEL_RISE && edges.fall &&
		!flag_r |=> !flag_r)
	else
		$error("rising mode flagged a falling edge");

	a_digin_off:
	assert property (clk_en && pos_off_r |=> !port_pin_pos)
	else
		$error("disabled pin did not read zero");

endmodule

// File: test/cei_cpu_model.sv
/*
 Far side model: the CPU entering the comparator interrupt vector.
 Assumes one clock shared with the design and a synchronous reset.
*/
module cei_cpu_model
(
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic irq_req,
	input  wire logic take_en,
	input  wire logic slow,
	output logic      vector_ack
);
	timeunit 1ns;
	timeprecision 1ns;

	int wait_c;

	initial vector_ack = 1'b0;

	// ==========================================================
	// Vector entry, at once or after a few cycles of latency
	// A pending pulse blocks a second entry on the same request
	always @(posedge clk)
	begin
		vector_ack <= 1'b0;
		if (!reset_n || !take_en || !irq_req || vector_ack)
			wait_c <= 0;
		else if (wait_c >= (slow ? 4 : 0))
		begin
			vector_ack <= 1'b1;
			wait_c <= 0;
		end
		else
			wait_c <= wait_c + 1;
	end
endmodule

// File: test/cei_top_tb_top.sv
/*
 Self-checking bench of the comparator event block.
 Assumes the design files and the CPU model are compiled first.
*/
`include "cei_cfg.svh"

module cei_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        cmp_raw = 1'b0, pos_pin_raw = 1'b0, neg_pin_raw = 1'b0;
	logic        icp_pin = 1'b0, global_irq_en = 1'b0, vector_ack;
	logic        cmp_irq_req, capture_in, port_pin_pos, port_pin_neg;
	logic        pos_digin_en, neg_digin_en, irq, take = 1'b0, slow = 1'b0;
	int          m_flag, m_ctl, m_lvl, m_digital_input_disable, m_stat, m_en;
	int          n_errors, n_checks, seed = 32'hee22;
	logic [1:0]  lane_resp;
	logic [7:0]  regs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};

	always #25 clk = ~clk;

	cei_top #(.AW(8)) dut
	(
		.clk, .reset_n, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_raw,
		.pos_pin_raw, .neg_pin_raw, .icp_pin, .global_irq_en,
		.vector_ack, .cmp_irq_req, .capture_in, .port_pin_pos,
		.port_pin_neg, .pos_digin_en, .neg_digin_en, .irq
	);

	cei_cpu_model cpu
	(
		.clk, .reset_n, .irq_req(cmp_irq_req), .take_en(take), .slow,
		.vector_ack
	);

	// ==========================================================
	// Reporting
	task automatic note(input logic ok, input string what);
		n_checks++;
		if (!ok)
		begin
			n_errors++;
			$display("wrong value at %0t ns: %s", $time, what);
		end
	endtask

	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		note(g === e, "register data");
	endtask

	task automatic chk_pin(input logic g, input logic e);
		note(g === e, "pin level");
	endtask

	task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
		note(g === e, "bus response");
	endtask

	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ==========================================================
	// Reference model
	function automatic logic [1:0] exp_resp(input logic [7:0] a);
		return (a inside {regs}) ? `CEI_RESP_OKAY : `CEI_RESP_SLVERR;
	endfunction

	function automatic logic [31:0] exp_csr();
		return (m_lvl << 5) | (m_flag << 4) | m_ctl;
	endfunction

	// Waits past the synchroniser so every edge has been seen
	task automatic set_cmp(input int v);
		int ev;
		cmp_raw <= v[0];
		repeat (4) @(posedge clk);
		if (v[0] != m_lvl[0])
		begin
			ev = m_ctl[1:0] == 0 || m_ctl[1:0] == (v[0] ? 3 : 2);
			m_flag |= ev;
			m_stat |= ev | 2;
			m_lvl = v[0];
		end
	endtask

	// ==========================================================
	// Register bus master
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk_resp(r, exp_resp(a));
		case (a)
		`CEI_OFS_CSR:
		begin
			m_ctl = d[3:0];
			if (d[4])
				m_flag = 0;
		end
		`CEI_OFS_DIGITAL_INPUT_DISABLE: m_digital_input_disable = d[1:0];
		`CEI_OFS_IRQ_CLR: m_stat &= ~d[1:0];
		`CEI_OFS_IRQ_EN: m_en = d[1:0];
		default: ;
		endcase
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(a, d, r);
		chk_resp(r, exp_resp(a));
		if (exp_resp(a) == `CEI_RESP_OKAY)
			chk_reg(d, e);
	endtask

	// ==========================================================
	// Scenarios
	initial
	begin
		repeat (10) @(posedge clk);
		chk_pin(pos_digin_en, 1'b1);
		reset_n <= 1'b1;
		foreach (regs[i])
			rd_chk(regs[i], 0);
		rd_chk(8'h14, 0);
		wr_reg(8'h14, 32'h1f);
		for (int s = 0; s < 4; s++)
		begin
			wr_reg(`CEI_OFS_CSR, 32'h10 | s);
			set_cmp(1);
			rd_chk(`CEI_OFS_CSR, exp_csr());
			wr_reg(`CEI_OFS_CSR, s);
			rd_chk(`CEI_OFS_CSR, exp_csr());
			wr_reg(`CEI_OFS_CSR, 32'h10 | s);
			rd_chk(`CEI_OFS_CSR, exp_csr());
			set_cmp(0);
			rd_chk(`CEI_OFS_CSR, exp_csr());
		end
		wr_reg(`CEI_OFS_IRQ_STAT, 0);
		rd_chk(`CEI_OFS_IRQ_STAT, m_stat);
		wr_reg(`CEI_OFS_IRQ_EN, 3);
		chk_pin(irq, |(m_stat & m_en));
		wr_reg(`CEI_OFS_IRQ_CLR, 1);
		chk_pin(irq, |(m_stat & m_en));
		wr_reg(`CEI_OFS_IRQ_CLR, 2);
		chk_pin(irq, |(m_stat & m_en));
		rd_chk(`CEI_OFS_IRQ_STAT, m_stat);
		wr_reg(`CEI_OFS_IRQ_EN, 0);
		// A write without the low byte lane must leave the register alone
		s_axi_wstrb <= 4'h0;
		axi_wr(`CEI_OFS_IRQ_EN, 32'h3, lane_resp);
		chk_resp(lane_resp, `CEI_RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rd_chk(`CEI_OFS_IRQ_EN, m_en);
		wr_reg(`CEI_OFS_CSR, 32'h10);
		for (int i = 0; i < 4; i++)
		begin
			global_irq_en <= 1'($random(seed));
			slow <= i[0];
			set_cmp(m_lvl ^ 1);
			chk_pin(cmp_irq_req, 1'b0);
			wr_reg(`CEI_OFS_CSR, 8);
			chk_pin(cmp_irq_req, global_irq_en);
			wr_reg(`CEI_OFS_CSR, 0);
			chk_pin(cmp_irq_req, 1'b0);
			wr_reg(`CEI_OFS_CSR, 8);
			chk_pin(cmp_irq_req, global_irq_en);
			take <= 1'b1;
			repeat (8) @(posedge clk);
			take <= 1'b0;
			if (global_irq_en)
				m_flag = 0;
			rd_chk(`CEI_OFS_CSR, exp_csr());
			wr_reg(`CEI_OFS_CSR, 32'h10);
		end
		for (int i = 0; i < 6; i++)
		begin
			// The capture route bit picks the synchronised comparator over icp_pin
			wr_reg(`CEI_OFS_CSR, i[0] ? 4 : 0);
			icp_pin <= 1'($random(seed));
			set_cmp($random(seed));
			chk_pin(capture_in, i[0] ? m_lvl[0] : icp_pin);
		end
		// Frozen block: no handshake, capture output holds its old level
		clk_en <= 1'b0;
		cmp_raw <= ~m_lvl[0];
		repeat (4) @(posedge clk);
		chk_pin(s_axi_awready, 1'b0);
		chk_pin(capture_in, m_lvl[0]);
		clk_en <= 1'b1;
		set_cmp(m_lvl ^ 1);
		rd_chk(`CEI_OFS_CSR, exp_csr());
		for (int i = 0; i < 6; i++)
		begin
			wr_reg(`CEI_OFS_DIGITAL_INPUT_DISABLE, $random(seed));
			{pos_pin_raw, neg_pin_raw} <= 2'($random(seed));
			repeat (3) @(posedge clk);
			chk_pin(port_pin_pos, pos_pin_raw & !m_digital_input_disable[0]);
			chk_pin(port_pin_neg, neg_pin_raw & !m_digital_input_disable[1]);
			chk_pin(pos_digin_en, !m_digital_input_disable[0]);
			chk_pin(neg_digin_en, !m_digital_input_disable[1]);
			rd_chk(`CEI_OFS_DIGITAL_INPUT_DISABLE, m_digital_input_disable);
		end
		end_sim();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		$display("wrong value at %0t ns: run hangs", $time);
		end_sim();
	end
endmodule
